// File: hdl/telegram_params.svh
// Constants of the serial telegram slave: character codes, address layout, line timing.
// Assumes a 25 MHz system clock and a master that speaks 9600 bit/s even-parity ASCII.
`ifndef TELEGRAM_PARAMS_SVH
`define TELEGRAM_PARAMS_SVH

// ---------------------------------------------------------------
// Line timing
// ---------------------------------------------------------------
`define CLOCK_HZ 25000000
`define LINE_BAUD 9600
`define BIT_CYCLES (`CLOCK_HZ / `LINE_BAUD)
`define TX_DEPTH 2

// ---------------------------------------------------------------
// Character codes
// ---------------------------------------------------------------
`define CH_STX 7'h02
`define CH_ETX 7'h03
`define CH_EOT 7'h04
`define CH_ENQ 7'h05
`define CH_ACK 7'h06
`define CH_NAK 7'h15
`define CH_EQUAL 7'h3D
`define CH_ZERO 7'h30
`define ADDR_BASE 7'h40
`define STN_ANY 5'h00
`define STN_ALL 5'h1F
`define STN_MAX 5'h1E
`define READ_LEN 4'hD

`endif

// File: hdl/telegram_pkg.sv
// Types shared by the telegram slave and its serial line modules.
// Assumes the constants header is on the include path.
package telegram_pkg;
`include "telegram_params.svh"

    typedef logic [6:0] char_t;

    // One received character with its error flag.
    typedef struct packed {
        logic valid;
        logic err;
        char_t data;
    } rx_char_t;

    // Variable access handed to the owner of the variables.
    typedef struct packed {
        logic write;
        logic [19:0] code;
        logic [15:0] wdata;
    } var_req_t;

    typedef enum logic [9:0] {
        S_IDLE = 10'h001, S_ADR = 10'h002, S_HEAD = 10'h004, S_CODE = 10'h008,
        S_TAIL = 10'h010, S_VAL = 10'h020, S_ETX = 10'h040, S_BCC = 10'h080,
        S_REQ = 10'h100, S_SEND = 10'h200
    } parse_state_t;

    typedef struct packed {
        parse_state_t st;
        logic [3:0] cnt;
        logic is_write;
        logic bcast;
        char_t adr;
        logic [19:0] code;
        logic [15:0] val;
        char_t bcc;
        logic short_rep;
        char_t rep_char;
        logic req;
    } slave_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic busy;
        logic [11:0] tick;
        logic [3:0] bit_n;
        logic [7:0] sh;
        rx_char_t out;
    } rx_state_t;

    typedef struct packed {
        logic [`TX_DEPTH-1:0][6:0] mem;
        logic rd;
        logic wr;
        logic [1:0] fill;
        logic busy;
        logic [11:0] tick;
        logic [3:0] bit_n;
        logic [9:0] sh;
        logic line;
        logic drive;
    } tx_state_t;

endpackage : telegram_pkg

// File: hdl/serial_rx.sv
// Serial character receiver with even parity and stop bit check.
// Assumes an idle-high line from outside the clock domain.
`timescale 1ns/1ns
`include "telegram_params.svh"
module serial_rx import telegram_pkg::*; #(
    parameter int BIT_CYCLES = `BIT_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Line and received character
    input wire logic rx_line,
    output rx_char_t rx_char
);
    rx_state_t s, next_s;

    // Samples mid-bit, shifting LSB first; error on bad parity or stop bit.
    always_comb begin
        next_s = s;
        next_s.s1 = rx_line;
        next_s.s2 = s.s1;
        next_s.out.valid = 1'b0;
        if (!s.busy) begin
            if (!s.s2) begin
                next_s.busy = 1'b1;
                next_s.bit_n = 4'h0;
                next_s.tick = 12'(BIT_CYCLES / 2);
            end
        end else if (s.tick != 12'h000) begin
            next_s.tick = s.tick - 12'h001;
        end else begin
            next_s.tick = 12'(BIT_CYCLES - 1);
            next_s.bit_n = s.bit_n + 4'h1;
            if (s.bit_n == 4'h0) begin
                next_s.busy = !s.s2;
            end else if (s.bit_n <= 4'h8) begin
                next_s.sh = {s.s2, s.sh[7:1]};
            end else begin
                next_s.busy = 1'b0;
                next_s.out.valid = 1'b1;
                next_s.out.data = s.sh[6:0];
                next_s.out.err = !s.s2 || (^s.sh);
            end
        end
    end

    // State register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{s1: 1'b1, s2: 1'b1, tick: 12'h000, bit_n: 4'h0, sh: 8'h00,
                   out: '0, busy: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign rx_char = s.out;
endmodule : serial_rx

// File: hdl/serial_tx.sv
// Two-entry character buffer feeding an even-parity serial transmitter.
// Assumes the writer honours in_ready; drive is high while a frame is on the line.
`timescale 1ns/1ns
`include "telegram_params.svh"
module serial_tx import telegram_pkg::*; #(
    parameter int BIT_CYCLES = `BIT_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Character input
    input wire logic in_valid,
    input wire char_t in_data,
    output logic in_ready,
    // Line
    output logic tx_line,
    output logic tx_drive
);
    tx_state_t s, next_s;
    logic push;
    logic pop;

    assign in_ready = (s.fill != 2'(`TX_DEPTH));
    assign push = in_valid && in_ready;
    assign pop = !s.busy && (s.fill != 2'h0);

    // Buffer bookkeeping and bit shifter; frame is start, 7 data, parity, stop.
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr] = in_data;
            next_s.wr = !s.wr;
        end
        next_s.fill = s.fill + 2'(push) - 2'(pop);
        if (pop) begin
            next_s.rd = !s.rd;
            next_s.busy = 1'b1;
            next_s.bit_n = 4'h0;
            next_s.tick = 12'(BIT_CYCLES - 1);
            next_s.sh = {1'b1, ^s.mem[s.rd], s.mem[s.rd], 1'b0};
            next_s.line = 1'b0;
            next_s.drive = 1'b1;
        end else if (s.busy) begin
            if (s.tick != 12'h000) begin
                next_s.tick = s.tick - 12'h001;
            end else if (s.bit_n == 4'h9) begin
                next_s.busy = 1'b0;
                next_s.drive = (s.fill != 2'h0);
            end else begin
                next_s.tick = 12'(BIT_CYCLES - 1);
                next_s.bit_n = s.bit_n + 4'h1;
                next_s.sh = {1'b1, s.sh[9:1]};
                next_s.line = s.sh[1];
            end
        end
    end

    // State register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{line: 1'b1, sh: 10'h3FF, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign tx_line = s.line;
    assign tx_drive = s.drive;
endmodule : serial_tx

// File: hdl/telegram_slave.sv
// Slave-side telegram handler: addressing, read and write parsing, replies.
// Assumes a variable owner that answers each var_req with one var_done pulse.
`timescale 1ns/1ns
`include "telegram_params.svh"
module telegram_slave import telegram_pkg::*; #(
    parameter int BIT_CYCLES = `BIT_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Serial line
    input wire logic rx_line,
    output logic tx_line,
    output logic tx_drive,
    // Configuration
    input wire logic [4:0] station_number_setting,
    // Variable access
    output logic var_req,
    output var_req_t var_out,
    input wire logic var_done,
    input wire logic var_ok,
    input wire logic [15:0] var_rdata
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------

    // Hex digit to nibble, with a valid flag.
    function automatic logic [4:0] hex_nib(input char_t c);
        if (c >= 7'h30 && c <= 7'h39) begin
            return {1'b1, c[3:0]};
        end else if (c >= 7'h41 && c <= 7'h46) begin
            return {1'b1, 4'(c[3:0] + 4'h9)};
        end
        return 5'h00;
    endfunction : hex_nib

    // Nibble to upper-case hex digit.
    function automatic char_t nib_hex(input logic [3:0] n);
        return (n < 4'hA) ? 7'(`CH_ZERO + 7'(n)) : 7'(7'h37 + 7'(n));
    endfunction : nib_hex

    // Address character selects this slave.
    function automatic logic addr_hit(input char_t c, input logic [4:0] stn);
        logic [4:0] num;
        num = c[4:0];
        return (c[6:5] == 2'(`ADDR_BASE >> 5)) && ((num == `STN_ANY) || (num == `STN_ALL)
            || (num == stn && stn != 5'h00 && stn <= `STN_MAX));
    endfunction : addr_hit

    // ---------------------------------------------------------------
    // Serial line
    // ---------------------------------------------------------------
    rx_char_t rxc;
    logic tx_ready;
    char_t out_char;
    slave_state_t s, next_s;
    logic parsing;
    logic is_dec;
    logic [4:0] hn;

    serial_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
        .clock(clock),
        .rst_n(rst_n),
        .rx_line(rx_line),
        .rx_char(rxc)
    );

    serial_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(s.st == S_SEND),
        .in_data(out_char),
        .in_ready(tx_ready),
        .tx_line(tx_line),
        .tx_drive(tx_drive)
    );

    // Receive is ignored while a request is served or a reply is sent.
    assign parsing = (s.st != S_REQ) && (s.st != S_SEND);
    assign is_dec = (rxc.data >= 7'h30) && (rxc.data <= 7'h39);
    assign hn = hex_nib(rxc.data);

    // ---------------------------------------------------------------
    // Reply character
    // ---------------------------------------------------------------

    // Picks the reply byte at the current index.
    always_comb begin
        out_char = s.adr;
        if (s.cnt == 4'h0) begin
            out_char = s.adr;
        end else if (s.short_rep) begin
            out_char = s.rep_char;
        end else if (s.cnt == 4'h1) begin
            out_char = `CH_STX;
        end else if (s.cnt <= 4'h6) begin
            out_char = nib_hex(s.code[4 * (6 - int'(s.cnt)) +: 4]);
        end else if (s.cnt == 4'h7) begin
            out_char = `CH_EQUAL;
        end else if (s.cnt <= 4'hB) begin
            out_char = nib_hex(s.val[4 * (11 - int'(s.cnt)) +: 4]);
        end else if (s.cnt == 4'hC) begin
            out_char = `CH_ETX;
        end else begin
            out_char = s.bcc;
        end
    end

    // ---------------------------------------------------------------
    // Parser and reply sequencer
    // ---------------------------------------------------------------

    // Walks the telegram one character at a time and steps the reply.
    always_comb begin
        next_s = s;
        next_s.req = 1'b0;
        if (rxc.valid && parsing) begin
            if (rxc.err) begin
                next_s.st = S_IDLE;
            end else if (rxc.data == `CH_EOT) begin
                next_s.st = S_ADR;
            end else begin
                next_s.st = S_IDLE;
                case (s.st)
                    S_ADR: begin
                        if (addr_hit(rxc.data, station_number_setting)) begin
                            next_s.adr = rxc.data;
                            next_s.bcast = (rxc.data[4:0] == `STN_ALL);
                            next_s.st = S_HEAD;
                        end
                    end
                    S_HEAD: begin
                        next_s.bcc = 7'h00;
                        if (rxc.data == `CH_STX) begin
                            next_s.is_write = 1'b1;
                            next_s.cnt = 4'h0;
                            next_s.st = S_CODE;
                        end else if (is_dec) begin
                            next_s.is_write = 1'b0;
                            next_s.code = {16'h0000, rxc.data[3:0]};
                            next_s.cnt = 4'h1;
                            next_s.st = S_CODE;
                        end
                    end
                    S_CODE: begin
                        if (is_dec) begin
                            next_s.code = {s.code[15:0], rxc.data[3:0]};
                            next_s.bcc = s.bcc ^ rxc.data;
                            next_s.cnt = s.cnt + 4'h1;
                            next_s.st = (s.cnt == 4'h4) ? S_TAIL : S_CODE;
                        end
                    end
                    S_TAIL: begin
                        if (s.is_write && rxc.data == `CH_EQUAL) begin
                            next_s.bcc = s.bcc ^ rxc.data;
                            next_s.cnt = 4'h0;
                            next_s.st = S_VAL;
                        end else if (!s.is_write && rxc.data == `CH_ENQ) begin
                            next_s.req = 1'b1;
                            next_s.st = S_REQ;
                        end
                    end
                    S_VAL: begin
                        if (hn[4]) begin
                            next_s.val = {s.val[11:0], hn[3:0]};
                            next_s.bcc = s.bcc ^ rxc.data;
                            next_s.cnt = s.cnt + 4'h1;
                            next_s.st = (s.cnt == 4'h3) ? S_ETX : S_VAL;
                        end
                    end
                    S_ETX: begin
                        if (rxc.data == `CH_ETX) begin
                            next_s.bcc = s.bcc ^ rxc.data;
                            next_s.st = S_BCC;
                        end
                    end
                    S_BCC: begin
                        if (rxc.data == s.bcc) begin
                            next_s.req = 1'b1;
                            next_s.st = S_REQ;
                        end else if (!s.bcast) begin
                            next_s.short_rep = 1'b1;
                            next_s.rep_char = `CH_NAK;
                            next_s.cnt = 4'h0;
                            next_s.st = S_SEND;
                        end
                    end
                    default: begin
                        next_s.st = S_IDLE;
                    end
                endcase
            end
        end else begin
            case (s.st)
                S_REQ: begin
                    if (var_done) begin
                        next_s.cnt = 4'h0;
                        next_s.bcc = 7'h00;
                        next_s.short_rep = s.is_write || !var_ok;
                        next_s.rep_char = var_ok ? `CH_ACK : `CH_NAK;
                        next_s.val = (s.is_write || !var_ok) ? s.val : var_rdata;
                        next_s.st = s.bcast ? S_IDLE : S_SEND;
                    end
                end
                S_SEND: begin
                    if (tx_ready) begin
                        next_s.cnt = s.cnt + 4'h1;
                        if (s.cnt >= 4'h2 && s.cnt <= 4'hC) begin
                            next_s.bcc = s.bcc ^ out_char;
                        end
                        if (s.cnt == (s.short_rep ? 4'h1 : `READ_LEN)) begin
                            next_s.st = S_IDLE;
                        end
                    end
                end
                default: begin
                    next_s.st = s.st;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{st: S_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign var_req = s.req;
    assign var_out = '{write: s.is_write, code: s.code, wdata: s.val};

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Variable handshake: one pulse per telegram, and only after a complete request.
    a_req_single: assert property (var_req |=> !var_req && s.st == S_REQ)
        else $error("Variable request is not a single pulse.");
    a_enq_req: assert property (s.st == S_TAIL && rxc.valid && !rxc.err
        && !s.is_write && rxc.data == `CH_ENQ |=> var_req)
        else $error("Complete read request did not reach the variable owner.");
    a_bcc_good: assert property (s.st == S_BCC && rxc.valid && !rxc.err
        && rxc.data == s.bcc && rxc.data != `CH_EOT |=> var_req && s.st == S_REQ)
        else $error("Write with a matching check character was not executed.");

    // Addressing and broadcast: foreign stations are ignored, broadcasts stay silent.
    a_bcast_silent: assert property (s.st == S_SEND |-> !s.bcast)
        else $error("Reply sent to a broadcast telegram.");
    a_bcast_idle: assert property (s.st == S_REQ && var_done && s.bcast
        |=> s.st == S_IDLE)
        else $error("Broadcast telegram did not return to idle.");
    a_adr_first: assert property (s.st == S_SEND && s.cnt == 4'h0
        |-> out_char == s.adr && out_char[6:5] == 2'b10)
        else $error("Reply does not open with the address character.");
    a_foreign_adr: assert property (s.st == S_ADR && rxc.valid && !rxc.err
        && rxc.data != `CH_EOT && (rxc.data[6:5] != 2'b10 || (rxc.data[4:0] != `STN_ANY
        && rxc.data[4:0] != `STN_ALL && rxc.data[4:0] != station_number_setting))
        |=> s.st == S_IDLE)
        else $error("Foreign address character was accepted.");

    // Reply content: short answers, full read answers and their check character.
    a_short_reply: assert property (s.st == S_SEND && s.short_rep && s.cnt == 4'h1
        |-> out_char == `CH_ACK || out_char == `CH_NAK)
        else $error("Short reply is neither ACK nor NAK.");
    a_write_ack: assert property (s.st == S_REQ && var_done && var_ok && s.is_write
        && !s.bcast |=> s.st == S_SEND && s.short_rep && s.rep_char == `CH_ACK)
        else $error("Accepted write not answered with ACK.");
    a_read_nak: assert property (s.st == S_REQ && var_done && !var_ok && !s.bcast
        |=> s.st == S_SEND && s.short_rep && s.rep_char == `CH_NAK)
        else $error("Refused access not answered with NAK.");
    a_bcc_nak: assert property (s.st == S_BCC && rxc.valid && !rxc.err
        && rxc.data != s.bcc && !s.bcast && rxc.data != `CH_EOT
        |=> s.st == S_SEND && s.rep_char == `CH_NAK && !var_req)
        else $error("Bad check character not answered with NAK.");
    a_read_len: assert property (s.st == S_SEND && !s.short_rep && s.cnt == `READ_LEN
        && tx_ready |-> out_char == s.bcc ##1 s.st == S_IDLE)
        else $error("Read reply does not end with the check character.");

    // Restart on errors, and a quiet line whenever the driver is released.
    a_eot_restart: assert property (parsing && rxc.valid && !rxc.err
        && rxc.data == `CH_EOT |=> s.st == S_ADR)
        else $error("EOT did not restart the parser.");
    a_parity_drop: assert property (parsing && rxc.valid && rxc.err
        |=> s.st == S_IDLE)
        else $error("Character error did not drop the telegram.");
    a_no_talk_rx: assert property (s.st == S_SEND && rxc.valid |=> !var_req)
        else $error("Received character acted upon during a reply.");
    a_tx_idle: assert property (!tx_drive |-> tx_line)
        else $error("Transmit line not idle high while released.");

    // Main scenarios that the bench is expected to reach.
    c_read_reply: cover property (s.st == S_SEND && !s.short_rep && s.cnt == `READ_LEN);
    c_write_ack: cover property (s.st == S_SEND && s.rep_char == `CH_ACK && s.cnt == 4'h1);
    c_bcast_exec: cover property (s.st == S_REQ && s.bcast && var_done);
    c_read_nak: cover property (s.st == S_REQ && var_done && !var_ok && !s.is_write);
    c_bcc_nak: cover property (s.st == S_BCC && rxc.valid && !rxc.err && rxc.data != s.bcc);
endmodule : telegram_slave

// File: verif/serial_master.sv
// Behavioural bus master for the telegram slave: sends framed characters, collects replies.
// Assumes the slave's line idles high and its drive flag marks its own frames.
`timescale 1ns/1ns
module serial_master import telegram_pkg::*; #(
    parameter int BIT_CYCLES = 16
) (
    // Clock
    input wire logic clock,
    // Lines
    output logic line,
    input wire logic tx_line,
    input wire logic tx_drive
);
    // The master line rests high between frames.
    initial line = 1'b1;

    // Sends one frame; bad_par flips the parity bit to provoke a character error.
    task automatic send_char(input char_t c, input logic bad_par);
        logic [9:0] f;
        f = {1'b1, (^c) ^ bad_par, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            #1;
            line = f[i];
            repeat (BIT_CYCLES - 1) @(posedge clock);
        end
    endtask : send_char

    // Waits a bounded time for a start bit, then samples each bit at its middle.
    task automatic get_char(input int limit, output char_t c, output logic ok);
        logic [7:0] b;
        ok = 1'b0;
        c = '0;
        b = '0;
        for (int n = 0; n < limit && !ok; n++) begin
            @(posedge clock);
            #1;
            ok = (tx_drive === 1'b1) && (tx_line === 1'b0);
        end
        if (ok) begin
            repeat (BIT_CYCLES / 2) @(posedge clock);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge clock);
                b[i] = tx_line;
            end
            repeat (BIT_CYCLES) @(posedge clock);
            ok = (tx_line === 1'b1) && (^b === 1'b0);
            c = b[6:0];
        end
    endtask : get_char
endmodule : serial_master

// File: verif/tb_top.sv
// Self-checking bench for the telegram slave at station 5, then station 30, with a short bit time.
// Assumes the master model drives the slave's receive line; the bench plays variable owner.
`timescale 1ns/1ns
module tb_top import telegram_pkg::*;;
    localparam int BC = 16;
    typedef struct packed {
        char_t adr;
        logic wr;
        logic [19:0] code;
        logic [15:0] val;
        logic bad;
        logic ok;
        logic [1:0] kind;
        logic req;
    } row_t;
    logic clock, rst_n, rx_line, tx_line, tx_drive, var_req, var_done, var_ok;
    logic [4:0] station_number_setting;
    logic [15:0] var_rdata;
    logic [1:0] dly;
    var_req_t var_out, last_req;
    int fails, num_checks, reqs;
    char_t none[$];
    // Columns: address, write, code, value, bad check, owner verdict, reply kind, request.
    row_t rows[8] = '{
        '{7'h45, 1'h0, 20'h00804, 16'h1FFF, 1'h0, 1'h1, 2'h3, 1'h1},
        '{7'h40, 1'h0, 20'h00800, 16'h0B8E, 1'h0, 1'h1, 2'h3, 1'h1},
        '{7'h45, 1'h0, 20'h00999, 16'h0000, 1'h0, 1'h0, 2'h2, 1'h1},
        '{7'h45, 1'h1, 20'h00804, 16'h1AAA, 1'h0, 1'h1, 2'h1, 1'h1},
        '{7'h45, 1'h1, 20'h00100, 16'hFC2D, 1'h0, 1'h0, 2'h2, 1'h1},
        '{7'h45, 1'h1, 20'h00804, 16'h0001, 1'h1, 1'h1, 2'h2, 1'h0},
        '{7'h5F, 1'h1, 20'h00803, 16'h0003, 1'h0, 1'h1, 2'h0, 1'h1},
        '{7'h46, 1'h0, 20'h00804, 16'h0001, 1'h0, 1'h1, 2'h0, 1'h0}
    };

    telegram_slave #(.BIT_CYCLES(BC)) dut (.clock(clock), .rst_n(rst_n), .rx_line(rx_line),
        .tx_line(tx_line), .tx_drive(tx_drive), .station_number_setting(station_number_setting),
        .var_req(var_req), .var_out(var_out), .var_done(var_done), .var_ok(var_ok),
        .var_rdata(var_rdata));
    serial_master #(.BIT_CYCLES(BC)) m (.clock(clock), .line(rx_line), .tx_line(tx_line),
        .tx_drive(tx_drive));

    // Free-running clock at 40 ns.
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Variable owner: notes each request and answers it with one pulse two cycles later.
    always @(posedge clock) begin
        #1;
        var_done = dly[1];
        dly = {dly[0], var_req === 1'b1};
        if (var_req === 1'b1) begin
            reqs++;
            last_req = var_out;
        end
    end

    // Compares two values and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // Upper-case hex digit character.
    function automatic char_t hx(input logic [3:0] n);
        return (n < 4'hA) ? 7'h30 + {3'h0, n} : 7'h37 + {3'h0, n};
    endfunction : hx

    // Appends code, separator, value, end-of-text and the check character.
    function automatic void body(input row_t r, ref char_t q[$]);
        char_t t[$];
        char_t b;
        b = '0;
        for (int i = 4; i >= 0; i--) t.push_back(hx(r.code[4*i+:4]));
        t.push_back(7'h3D);
        for (int i = 3; i >= 0; i--) t.push_back(hx(r.val[4*i+:4]));
        t.push_back(7'h03);
        foreach (t[i]) b ^= t[i];
        t.push_back(b ^ {6'h00, r.bad});
        q = {q, t};
    endfunction : body

    // Collects the expected reply characters, then demands a quiet line.
    task automatic expect_reply(input char_t q[$]);
        char_t c;
        logic ok;
        foreach (q[i]) begin
            m.get_char(40 * BC, c, ok);
            chk({ok, c}, {1'b1, q[i]});
        end
        m.get_char(40 * BC, c, ok);
        chk(ok, 1'b0);
    endtask : expect_reply

    // Sends one telegram from a row and checks the request and the reply.
    task automatic run_row(input row_t r);
        char_t q[$];
        int n0;
        q = {7'h04, r.adr};
        if (r.wr) begin
            q.push_back(7'h02);
            body(r, q);
        end else begin
            for (int i = 4; i >= 0; i--) q.push_back(hx(r.code[4*i+:4]));
            q.push_back(7'h05);
        end
        @(posedge clock);
        #1;
        var_ok = r.ok;
        var_rdata = r.val;
        n0 = reqs;
        foreach (q[i]) m.send_char(q[i], 1'b0);
        q = {};
        if (r.kind != 2'h0) q.push_back(r.adr);
        if (r.kind == 2'h1) q.push_back(7'h06);
        if (r.kind == 2'h2) q.push_back(7'h15);
        if (r.kind == 2'h3) begin
            q.push_back(7'h02);
            body(r, q);
        end
        expect_reply(q);
        chk(reqs - n0, {31'h0, r.req});
        if (r.req) chk({last_req.write, last_req.code}, {r.wr, r.code});
        if (r.req && r.wr) chk(last_req.wdata, r.val);
    endtask : run_row

    // Watchdog against a hung run.
    initial begin
        repeat (100000) @(posedge clock);
        fails++;
        close_out();
    end

    // Main sequence: reset, table rows, then aborts and character errors.
    initial begin
        rst_n = 1'b0;
        station_number_setting = 5'h05;
        repeat (5) @(posedge clock);
        #1;
        chk({tx_line, tx_drive, var_req}, 3'h4);
        rst_n = 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        m.send_char(7'h04, 1'b0);
        m.send_char(7'h45, 1'b0);
        m.send_char(7'h30, 1'b0);
        run_row(rows[0]);
        m.send_char(7'h04, 1'b0);
        m.send_char(7'h45, 1'b0);
        m.send_char(7'h30, 1'b1);
        for (int i = 3; i >= 0; i--) m.send_char(hx(rows[0].code[4*i+:4]), 1'b0);
        m.send_char(7'h05, 1'b0);
        expect_reply(none);
        // Second reset in mid-run, then the top station number of the range.
        #1;
        rst_n = 1'b0;
        station_number_setting = 5'h1E;
        repeat (2) @(posedge clock);
        #1;
        chk({tx_line, tx_drive, var_req}, 3'h4);
        rst_n = 1'b1;
        run_row('{7'h5E, 1'h0, 20'h00808, 16'h04DA, 1'h0, 1'h1, 2'h3, 1'h1});
        run_row('{7'h45, 1'h0, 20'h00804, 16'h0001, 1'h0, 1'h1, 2'h0, 1'h0});
        close_out();
    end
endmodule : tb_top
